// File: src/aelf_top.sv
`timescale 1ns/10ps
`default_nettype none
module aelf_top (
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic [7:0]  thermal_fault_live,
	input  wire logic [7:0]  clock_monitor_live,
	input  wire logic [7:0]  power_event_live,
	input  wire logic [23:0] source_enable,
	input  wire logic [23:0] source_clear,
	input  wire logic        irq_enable,
	input  wire logic        reg_read,
	input  wire logic [15:0] reg_addr,
	output logic      [7:0]  reg_rdata,
	output logic             reg_rvalid,
	output logic             irq
);
	import aelf_pkg::*;

	aelf_if link ();

	logic [23:0] live_all;
	logic        power_up_complete_live;
	logic [23:0] sync1_q;
	logic [23:0] sync2_q;
	logic [23:0] sync3_q;
	logic [23:0] stable_q;
	logic [23:0] stable_d;
	logic [23:0] flag_prev_q;
	logic        irq_q;
	logic        irq_d;
	logic [7:0]  rdata_q;
	logic [7:0]  rdata_d;
	logic        rvalid_q;

	// Power-up complete is high while the amplifier reports active state
	assign power_up_complete_live = power_event_live[PWRUP_IDX - 16]; // [R12]
	assign live_all = {power_event_live[7:6], power_up_complete_live,
		power_event_live[4:0], clock_monitor_live, thermal_fault_live};

	// Raw sources come from analog monitors; glitches shorter than a cycle
	// are rejected because stages two and three must agree
	assign stable_d = (sync2_q & sync3_q) | (stable_q & (sync2_q | sync3_q));
	assign link.rise   = stable_d & ~stable_q & SRC_IMPL_MASK; // [R4] [R12]
	assign link.enable = source_enable;
	assign link.clear  = source_clear; // [R10] [R11]

	aelf_latch_bank u_bank (
		.clock (clock),
		.reset (reset),
		.bus   (link)
	);

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sync1_q  <= 24'h000000;
			sync2_q  <= 24'h000000;
			sync3_q  <= 24'h000000;
			stable_q <= 24'h000000;
		end else begin
			sync1_q  <= live_all;
			sync2_q  <= sync1_q;
			sync3_q  <= sync2_q;
			stable_q <= stable_d;
		end
	end

	// One-cycle request per cycle in which any flag newly turns on
	assign irq_d = irq_enable && ((link.flag & ~flag_prev_q) != 24'h000000); // [R7]

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			flag_prev_q <= 24'h000000;
			irq_q       <= 1'b0;
		end else begin
			flag_prev_q <= link.flag;
			irq_q       <= irq_d;
		end
	end

	wire hit_state1 = reg_addr == ADDR_STATE1;
	wire hit_state2 = reg_addr == ADDR_STATE2;
	wire hit_state3 = reg_addr == ADDR_STATE3; // [R3]
	wire hit_flag1  = reg_addr == ADDR_FLAG1; // [R8] [R9]
	wire hit_flag2  = reg_addr == ADDR_FLAG2;
	wire hit_flag3  = reg_addr == ADDR_FLAG3;

	// Unmapped addresses read as zero
	assign rdata_d = ({8{hit_state1}} & link.state[7:0])
		| ({8{hit_state2}} & link.state[15:8])
		| ({8{hit_state3}} & link.state[23:16])
		| ({8{hit_flag1}}  & link.flag[7:0])
		| ({8{hit_flag2}}  & link.flag[15:8])
		| ({8{hit_flag3}}  & link.flag[23:16]);

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			rdata_q  <= REG_RESET;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= reg_read;
			if (reg_read) begin
				rdata_q <= rdata_d;
			end
		end
	end

	assign reg_rdata  = rdata_q;
	assign reg_rvalid = rvalid_q;
	assign irq        = irq_q;

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	AST_IRQ_ON_FLAG_RISE: assert property ( // [R7]
		irq_enable && ((link.flag & ~flag_prev_q) != 24'h000000)
		|=> irq)
		else $error("no interrupt on flag rising edge");
	AST_IRQ_CAUSE: assert property ( // [R7]
		irq |-> $past(irq_enable)
		&& ($past(link.flag & ~flag_prev_q) != 24'h000000))
		else $error("interrupt without flag rising edge");
	AST_IRQ_MASKED: assert property (!irq_enable |=> !irq) // [R7]
		else $error("interrupt while output disabled");
	AST_READ_STATE3: assert property ( // [R3]
		reg_read && hit_state3
		|=> reg_rvalid && reg_rdata == $past(link.state[23:16]))
		else $error("state register 3 read wrong");
	AST_READ_FLAG1: assert property ( // [R6] [R8] [R9]
		reg_read && hit_flag1
		|=> reg_rvalid && reg_rdata
		== ($past(link.state[7:0]) & $past(source_enable[7:0])))
		else $error("flag register 1 read wrong");
	AST_RVALID_TIMING: assert property (reg_rvalid == $past(reg_read))
		else $error("read answer not one cycle after request");
	AST_RDATA_HOLD: assert property (!reg_read |=> $stable(reg_rdata))
		else $error("read data changed without a read");
	AST_SYNC_RISE: assert property ( // [R4]
		((stable_q & ~$past(stable_q)) & ~$past(sync2_q & sync3_q))
		== 24'h000000)
		else $error("raw input accepted before stages agreed");
	AST_SYNC_FALL: assert property (
		((~stable_q & $past(stable_q)) & $past(sync2_q | sync3_q))
		== 24'h000000)
		else $error("raw input dropped before stages agreed");
	AST_PWRUP_LATCH: assert property ( // [R12]
		$rose(sync3_q[PWRUP_IDX]) && sync2_q[PWRUP_IDX]
		&& !stable_q[PWRUP_IDX] |=> link.state[PWRUP_IDX])
		else $error("power-up complete not latched");
	COV_IRQ: cover property (irq);
	COV_READ_FLAG1: cover property (reg_read && hit_flag1);
endmodule : aelf_top
`default_nettype wire

// File: shared/aelf_pkg.sv
// Functional notes
// (R1) Clock-fault state bit sets on raw rising edge, holds until cleared, never masked.
// (R2) Data-monitor fault state bit latches rising edge, ignores enables, clears only by clear.
// (R3) State register 3 holds power and headroom events in bits 5..0, resets zero.
// (R4) Every state bit is one exactly when its raw source rose since last clear; bits outside SRC_IMPL_MASK (11, 14, 15, 22, 23) stay zero.
// (R5) Headroom begin (bit 1) and end (bit 0) latch their own rising edges.
// (R6) Flag reads one only with enable high and a rising edge since clear.
// (R7) With the interrupt output enabled, each flag zero-to-one transition raises an interrupt.
// (R8) Flag register 1 holds thermal shutdown, warning and foldback begin/end in bits 7..2.
// (R9) Flag register 1 bit 1 is memory failure, bit 0 speaker overcurrent, each enabled.
// (R10) Host must pulse a source's clear after handling it; bits never self-clear.
// (R11) One per-source clear resets both that source's state bit and flag bit.
// (R12) Raw power-up-complete is high while reporting active state with amplifier enabled.
// (R13) Clear is one cycle; a rising edge in the clear cycle leaves the latch set.
package aelf_pkg;
	localparam int NUM_SRC = 24;
	// Source index is group * 8 + bit; group 0 thermal, 1 clock/monitor, 2 power
	localparam logic [23:0] SRC_IMPL_MASK = 24'h3F37FF;
	localparam int SPK_OVC_IDX   = 0;
	localparam int OTP_FAIL_IDX  = 1;
	localparam int THERM_SD_BGN  = 7;
	localparam int DMON_IDX      = 8;
	localparam int CLK_FAULT_IDX = 9;
	localparam int HDRM_END_IDX  = 16;
	localparam int HDRM_BGN_IDX  = 17;
	localparam int PWRUP_IDX     = 21;
	localparam logic [15:0] ADDR_STATE1 = 16'h2006;
	localparam logic [15:0] ADDR_STATE2 = 16'h2007;
	localparam logic [15:0] ADDR_STATE3 = 16'h2008;
	localparam logic [15:0] ADDR_FLAG1  = 16'h200B;
	localparam logic [15:0] ADDR_FLAG2  = 16'h200C;
	localparam logic [15:0] ADDR_FLAG3  = 16'h200D;
	localparam logic [7:0]  REG_RESET   = 8'h00;
	localparam int SYNC_STAGES = 3;
endpackage : aelf_pkg

// File: shared/aelf_if.sv
`timescale 1ns/10ps
`default_nettype none
interface aelf_if;
	logic [23:0] rise;
	logic [23:0] enable;
	logic [23:0] clear;
	logic [23:0] state;
	logic [23:0] flag;
	modport bank (input rise, input enable, input clear,
		output state, output flag);
	modport ctrl (output rise, output enable, output clear,
		input state, input flag);
endinterface : aelf_if
`default_nettype wire

// File: src/aelf_latch_bank.sv
`timescale 1ns/10ps
`default_nettype none
module aelf_latch_bank (
	input  wire logic clock,
	input  wire logic reset,
	aelf_if.bank      bus
);
	import aelf_pkg::*;

	logic [23:0] state_q;
	logic [23:0] state_d;

	genvar i;
	generate
		for (i = 0; i < NUM_SRC; i++) begin : g_src
			if (SRC_IMPL_MASK[i]) begin : g_impl
				// Set beats clear so an edge in the clear cycle survives
				assign state_d[i] = bus.rise[i]
					| (state_q[i] & ~bus.clear[i]); // [R1] [R2] [R4] [R5] [R11] [R13]
			end else begin : g_none
				assign state_d[i] = 1'b0; // [R3]
			end
		end
	endgenerate

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state_q <= 24'h000000;
		end else begin
			state_q <= state_d;
		end
	end

	assign bus.state = state_q;
	// Flag is the latched event seen through its enable: one clear resets
	// both, and raising an enable exposes an event latched while it was low
	assign bus.flag  = state_q & bus.enable; // [R6] [R8] [R9] [R11]

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	AST_CLK_FAULT_SET: assert property ( // [R1]
		bus.rise[CLK_FAULT_IDX]
		|=> bus.state[CLK_FAULT_IDX][*3]
			or ##[0:2] bus.clear[CLK_FAULT_IDX])
		else $error("clock fault state not latched");
	AST_DMON_HOLD: assert property ( // [R2]
		bus.state[DMON_IDX] && !bus.clear[DMON_IDX]
		|=> bus.state[DMON_IDX])
		else $error("data monitor state dropped without clear");
	AST_STATE3_UNUSED: assert property (bus.state[23:22] == 2'h0) // [R3]
		else $error("unused state bits set");
	AST_STATE_CAUSE: assert property ( // [R4]
		((bus.state & ~$past(bus.state)) & ~$past(bus.rise))
		== 24'h000000)
		else $error("state bit set without raw rising edge");
	AST_HDRM_LATCH: assert property ( // [R5]
		(bus.state[17:16] & $past(bus.rise[17:16]))
		== $past(bus.rise[17:16]))
		else $error("headroom event not latched");
	AST_FLAG_MASKED: assert property ( // [R6]
		((bus.flag & ~bus.enable)
		| (bus.flag & ~$past(bus.flag) & ~$past(bus.rise)
		& ~(bus.enable & ~$past(bus.enable)))) == 24'h000000)
		else $error("flag visible without enable or event");
	AST_OVC_FLAG: assert property ( // [R8] [R9]
		bus.rise[SPK_OVC_IDX] && bus.enable[SPK_OVC_IDX]
		##1 bus.enable[SPK_OVC_IDX] |-> bus.flag[SPK_OVC_IDX])
		else $error("overcurrent flag not set");
	AST_CLEAR_BOTH: assert property ( // [R11]
		bus.clear[THERM_SD_BGN] && !bus.rise[THERM_SD_BGN]
		|=> !bus.state[THERM_SD_BGN] && !bus.flag[THERM_SD_BGN])
		else $error("clear did not reset state and flag");
	AST_SET_WINS: assert property ( // [R13]
		(bus.rise & bus.clear) != 24'h000000
		|=> (bus.state & $past(bus.rise & bus.clear))
		== $past(bus.rise & bus.clear))
		else $error("event lost in clear cycle");
	COV_STATE_SET: cover property (bus.rise[CLK_FAULT_IDX]
		##1 bus.state[CLK_FAULT_IDX]);
	COV_FLAG_CLEAR: cover property (bus.flag[SPK_OVC_IDX]
		##1 bus.clear[SPK_OVC_IDX]);
	COV_RACE: cover property ((bus.rise & bus.clear) != 24'h000000);
endmodule : aelf_latch_bank
`default_nettype wire

// File: tb/aelf_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module aelf_host_model (
	input  wire logic        clock,
	input  wire logic [7:0]  reg_rdata,
	input  wire logic        reg_rvalid,
	output logic             reg_read,
	output logic      [15:0] reg_addr,
	output logic      [23:0] source_clear
);
	initial begin
		reg_read = 1'b0;
		reg_addr = 16'h0000;
		source_clear = 24'h000000;
	end
	// Unknown result when no answer came, so a missing rvalid never matches
	task automatic read(input logic [15:0] a, output logic [7:0] d);
		d = 8'hXX;
		@(posedge clock);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_read <= 1'b0;
		@(posedge clock);
		if (reg_rvalid === 1'b1)
			d = reg_rdata;
	endtask : read
	// Latches never drop on their own, so the host clears once handled
	task automatic clear(input logic [23:0] m, input int n);
		@(posedge clock);
		source_clear <= m;
		repeat (n) @(posedge clock);
		source_clear <= 24'h000000;
	endtask : clear
endmodule : aelf_host_model
`default_nettype wire

// File: tb/tb_aelf_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_aelf_top;
	import aelf_pkg::*;
	localparam logic [15:0] ADDRS [7] = '{ADDR_STATE1, ADDR_STATE2,
		ADDR_STATE3, ADDR_FLAG1, ADDR_FLAG2, ADDR_FLAG3, 16'h2009};
	logic        clock = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  thermal = 8'h00;
	logic [7:0]  clkmon = 8'h00;
	logic [7:0]  power = 8'h00;
	logic [23:0] enable = 24'h000000;
	logic        irq_enable = 1'b0;
	logic        reg_read;
	logic [15:0] reg_addr;
	logic [23:0] source_clear;
	logic [7:0]  reg_rdata;
	logic        reg_rvalid;
	logic        irq;
	int          fails = 0;
	int          checked = 0;
	int          irqs = 0;
	int          cycles = 0;
	always #5 clock = ~clock;
	aelf_top dut (.clock(clock), .reset(reset),
		.thermal_fault_live(thermal), .clock_monitor_live(clkmon),
		.power_event_live(power), .source_enable(enable),
		.source_clear(source_clear), .irq_enable(irq_enable),
		.reg_read(reg_read), .reg_addr(reg_addr),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .irq(irq));
	aelf_host_model host (.clock(clock), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .reg_read(reg_read),
		.reg_addr(reg_addr), .source_clear(source_clear));
	task automatic tally_and_finish;
		$display("Checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (irq === 1'b1)
			irqs <= irqs + 1;
		if (cycles == 1000) begin
			fails = fails + 1;
			tally_and_finish();
		end
	end
	task automatic expect_reg(input logic [15:0] a, input logic [7:0] e);
		logic [7:0] d;
		host.read(a, d);
		checked++;
		if (d !== e) begin
			fails++;
			$display("Error reg %h expected %h seen %h", a, e, d);
		end
	endtask : expect_reg
	task automatic expect_irqs(input int e);
		checked++;
		if (irqs != e) begin
			fails++;
			$display("Error irq count expected %0d seen %0d", e, irqs);
		end
	endtask : expect_irqs
	// Sync chain needs four edges; six leaves margin without guessing
	task automatic settle;
		repeat (6) @(posedge clock);
	endtask : settle
	initial begin
		repeat (5) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		foreach (ADDRS[i]) expect_reg(ADDRS[i], REG_RESET);
		enable <= 24'h2000FF;
		irq_enable <= 1'b1;
		thermal <= 8'hFF;
		settle();
		expect_reg(ADDR_FLAG1, 8'hFF);
		expect_reg(ADDR_STATE1, 8'hFF);
		expect_irqs(1);
		clkmon <= 8'h03;
		settle();
		expect_reg(ADDR_STATE2, 8'h03);
		expect_reg(ADDR_FLAG2, 8'h00);
		power <= 8'h3F;
		settle();
		expect_reg(ADDR_STATE3, 8'h3F);
		expect_reg(ADDR_FLAG3, 8'h20);
		expect_irqs(2);
		thermal <= 8'h00;
		power <= 8'h00;
		host.clear(24'h010081, 1);
		settle();
		expect_reg(ADDR_STATE1, 8'h7E);
		expect_reg(ADDR_FLAG1, 8'h7E);
		expect_reg(ADDR_STATE3, 8'h3E);
		// Clear held across the capture edge must lose to the new event
		power <= 8'h01;
		host.clear(24'h010000, 3);
		settle();
		expect_reg(ADDR_STATE3, 8'h3F);
		expect_reg(ADDR_STATE2, 8'h03);
		expect_irqs(2);
		// Output disabled: the flag still latches but no request follows
		irq_enable <= 1'b0;
		thermal <= 8'h80;
		settle();
		expect_reg(ADDR_FLAG1, 8'hFE);
		expect_irqs(2);
		// Enabling a source exposes its earlier event and requests once
		irq_enable <= 1'b1;
		enable <= 24'h2001FF;
		settle();
		expect_reg(ADDR_FLAG2, 8'h01);
		expect_irqs(3);
		tally_and_finish();
	end
endmodule : tb_aelf_top
`default_nettype wire
